//--- pkg/vcir_pkg.sv
package vcir_pkg;

  // Encoding key is {op0, op1, crn, crm, op2}; crn is 5 bits wide to hold every encoding
  localparam int ENC_W = 17;

  // Encodings of the stored registers
  localparam logic [16:0] ENC_BP_GRP0 = {2'h3, 3'h0, 5'h0C, 4'h8, 3'h3};
  localparam logic [16:0] ENC_BP_GRP1 = {2'h3, 3'h0, 5'h0C, 4'hC, 3'h3};
  localparam logic [16:0] ENC_CONTROL = {2'h3, 3'h0, 5'h0C, 4'hC, 3'h4};
  localparam logic [16:0] ENC_AP_GRP0 = {2'h3, 3'h0, 5'h0C, 4'h8, 3'h4};
  localparam logic [16:0] ENC_AP_GRP1 = {2'h3, 3'h0, 5'h13, 4'h9, 3'h0};

  // Encodings of the write-only end and deactivate registers
  localparam logic [16:0] ENC_END_GRP0 = {2'h3, 3'h0, 5'h0C, 4'h8, 3'h1};
  localparam logic [16:0] ENC_END_GRP1 = {2'h3, 3'h0, 5'h0C, 4'hC, 3'h1};
  localparam logic [16:0] ENC_DEACT = {2'h3, 3'h0, 5'h0C, 4'hB, 3'h1};

  // Split point field and its limits
  localparam int BP_MSB = 2;
  localparam logic [2:0] BP0_MIN = 3'h2;
  localparam logic [2:0] BP1_S_MIN = 3'h2;
  localparam logic [2:0] BP1_NS_MIN = 3'h3;
  localparam logic [2:0] BP_MAX = 3'h7;

  // Control register field positions
  localparam int CTL_SHARED_BIT = 0;
  localparam int CTL_EOI_BIT = 1;
  localparam int CTL_PRI_LSB = 8;
  localparam int CTL_ID_LSB = 11;
  localparam int CTL_SYS_ERROR_IRQ_SUPPORT_BIT = 14;
  localparam int CTL_A3V_BIT = 15;

  // Fixed feature values of the control register
  localparam logic CTL_A3V_VAL = 1'b1;
  localparam logic CTL_SYS_ERROR_IRQ_SUPPORT_VAL = 1'b0;
  localparam logic [2:0] CTL_ID_VAL = 3'h0;
  localparam logic [2:0] CTL_PRI_VAL = 3'h4;

  // Reset values
  localparam logic CTL_EOI_RST = 1'b0;
  localparam logic CTL_SHARED_RST = 1'b0;
  localparam logic [31:0] AP_RST = 32'h00000000;

  // Active priority map geometry: bit n stands for priority n * 8
  localparam int PRIO_SHIFT = 3;
  localparam int IDX_W = 5;
  localparam int ID_W = 16;

endpackage

//--- hdl/vcir_prio_map.sv
`timescale 1ns/100ps
module vcir_prio_map import vcir_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Software write of the whole map
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  // Activation of one level
  input wire logic set_en,
  input wire logic [4:0] set_idx,
  // Priority drop of the highest active level
  input wire logic drop_en,
  // Current map
  output logic [31:0] map
);

  typedef struct packed {
    logic [31:0] map; // One bit per active level
  } vcir_map_s;

  vcir_map_s st; // Registered state
  vcir_map_s next_st; // Next state
  logic [31:0] low_bit; // Lowest set bit, the highest priority
  logic [31:0] base; // Map after software write
  logic [31:0] set_mask; // Level being activated

  // Lowest index is the highest priority, so a drop clears it
  assign low_bit = st.map & (~st.map + 32'h00000001);
  assign set_mask = set_en ? (32'h00000001 << set_idx) : 32'h00000000;

  // Next map: write, then drop, then set; set wins over any clear
  always_comb begin
    next_st = st;
    base = wr_en ? wr_data : st.map;
    if (drop_en) begin
      base = base & ~low_bit;
    end
    next_st.map = base | set_mask;
  end

  // Map is empty after reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st.map <= AP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign map = st.map;

endmodule

//--- hdl/vcir_regs.sv
`timescale 1ns/100ps
// Contract
// - Group-0 split point in [2:0], minimum 2
// - Group-1 split minimum 2 secure, 3 non-secure
// - Control bit 15 reads constant one
// - Control bit 14 reads constant zero
// - Control bits 13:11 read constant zero
// - Control bits 10:8 read constant four
// - Mode 0: end write drops and deactivates
// - Mode 1: end drops, deactivate register deactivates
// - Shared off: each group uses own split
// - Shared on: group-0 split, read plus one
// - Keep 32-bit active priority bitmaps
// - Bit n means priority n times eight
// - Bitmaps reset to all zeros
// - Separate bitmaps for group 0 and 1
module vcir_regs import vcir_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // System register access request
  input wire logic sysreg_valid,
  input wire logic sysreg_write,
  input wire logic [1:0] sysreg_op0,
  input wire logic [2:0] sysreg_op1,
  input wire logic [4:0] sysreg_crn,
  input wire logic [3:0] sysreg_crm,
  input wire logic [2:0] sysreg_op2,
  input wire logic [31:0] sysreg_wdata,
  input wire logic secure_state,
  // System register access answer
  output logic sysreg_ack,
  output logic [31:0] sysreg_rdata,
  output logic sysreg_undef,
  // Interrupt activation
  input wire logic act_valid,
  input wire logic act_group,
  input wire logic [7:0] act_prio,
  // End of interrupt effects
  output logic prio_drop,
  output logic prio_drop_group,
  output logic deact,
  output logic [15:0] deact_id,
  // Effective split points for preemption
  output logic [2:0] split_grp0,
  output logic [2:0] split_grp1,
  // Active priority maps
  output logic [31:0] ap_grp0,
  output logic [31:0] ap_grp1
);

  typedef struct packed {
    logic [2:0] bp0; // Group-0 split point
    logic [2:0] bp1_s; // Group-1 split point, secure copy
    logic [2:0] bp1_ns; // Group-1 split point, non-secure copy
    logic eoi_split; // End-of-interrupt split mode
    logic shared; // Shared split point
    logic ack; // Answer strobe
    logic undef; // Unmapped access flag
    logic [31:0] rdata; // Read data
    logic drop; // Priority drop strobe
    logic drop_grp; // Group of the drop
    logic deact; // Deactivation strobe
    logic [15:0] deact_id; // Identifier being deactivated
    logic [2:0] eff0; // Effective group-0 split
    logic [2:0] eff1; // Effective group-1 split
  } vcir_state_s;

  vcir_state_s st; // Registered state
  vcir_state_s next_st; // Next state

  logic [16:0] key; // Encoding of the request
  logic wr; // Write taken this cycle
  logic rd; // Read taken this cycle
  logic hit_bp0; // Decoded targets
  logic hit_bp1;
  logic hit_ctl;
  logic hit_ap0;
  logic hit_ap1;
  logic hit_end0;
  logic hit_end1;
  logic hit_deact;
  logic hit_any; // Any mapped encoding
  logic [2:0] wr_bp; // Written split value
  logic [2:0] bp1_cur; // Group-1 copy for the current security state
  logic [2:0] bp1_view; // Group-1 value as software sees it
  logic [31:0] ctl_view; // Control register as read
  logic [31:0] rd_val; // Read mux result
  logic [4:0] act_idx; // Map bit of the activated priority
  logic set0; // Activation per group
  logic set1;
  logic drop0; // Drop per group
  logic drop1;
  logic [31:0] map0; // Map outputs of the two groups
  logic [31:0] map1;

  // Address decode of the request
  assign key = {sysreg_op0, sysreg_op1, sysreg_crn, sysreg_crm, sysreg_op2};
  assign wr = sysreg_valid & sysreg_write;
  assign rd = sysreg_valid & ~sysreg_write;
  assign hit_bp0 = (key == ENC_BP_GRP0);
  assign hit_bp1 = (key == ENC_BP_GRP1);
  assign hit_ctl = (key == ENC_CONTROL);
  assign hit_ap0 = (key == ENC_AP_GRP0);
  assign hit_ap1 = (key == ENC_AP_GRP1);
  assign hit_end0 = (key == ENC_END_GRP0);
  assign hit_end1 = (key == ENC_END_GRP1);
  assign hit_deact = (key == ENC_DEACT);
  assign hit_any = hit_bp0 | hit_bp1 | hit_ctl | hit_ap0 | hit_ap1 | hit_end0 | hit_end1 | hit_deact;

  // Only the low three bits of a split write are kept
  assign wr_bp = sysreg_wdata[BP_MSB:0];

  // Security state picks which group-1 copy is in play
  assign bp1_cur = secure_state ? st.bp1_s : st.bp1_ns;

  // Shared mode shows group-0 plus one, held at the top value
  always_comb begin
    if (st.shared) begin
      bp1_view = (st.bp0 == BP_MAX) ? BP_MAX : (st.bp0 + 3'h1);
    end else begin
      bp1_view = bp1_cur;
    end
  end

  // Control register view with fixed feature fields
  always_comb begin
    ctl_view = 32'h00000000;
    ctl_view[CTL_A3V_BIT] = CTL_A3V_VAL;
    ctl_view[CTL_SYS_ERROR_IRQ_SUPPORT_BIT] = CTL_SYS_ERROR_IRQ_SUPPORT_VAL;
    ctl_view[CTL_ID_LSB +: 3] = CTL_ID_VAL;
    ctl_view[CTL_PRI_LSB +: 3] = CTL_PRI_VAL;
    ctl_view[CTL_EOI_BIT] = st.eoi_split;
    ctl_view[CTL_SHARED_BIT] = st.shared;
  end

  // Read mux; write-only and unmapped encodings read zero
  always_comb begin
    rd_val = 32'h00000000;
    if (hit_bp0) begin
      rd_val[BP_MSB:0] = st.bp0;
    end else if (hit_bp1) begin
      rd_val[BP_MSB:0] = bp1_view;
    end else if (hit_ctl) begin
      rd_val = ctl_view;
    end else if (hit_ap0) begin
      rd_val = map0;
    end else if (hit_ap1) begin
      rd_val = map1;
    end else begin
      rd_val = 32'h00000000;
    end
  end

  // Activation picks one map bit from the top five priority bits
  assign act_idx = act_prio[PRIO_SHIFT +: IDX_W];
  assign set0 = act_valid & ~act_group;
  assign set1 = act_valid & act_group;

  // End writes drop the highest active level of their own group
  assign drop0 = wr & hit_end0;
  assign drop1 = wr & hit_end1;

  // Group-0 active priority map
  vcir_prio_map u_map_grp0 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr_en(wr & hit_ap0),
    .wr_data(sysreg_wdata),
    .set_en(set0),
    .set_idx(act_idx),
    .drop_en(drop0),
    .map(map0)
  );

  // Group-1 active priority map, kept apart from group 0
  vcir_prio_map u_map_grp1 (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wr_en(wr & hit_ap1),
    .wr_data(sysreg_wdata),
    .set_en(set1),
    .set_idx(act_idx),
    .drop_en(drop1),
    .map(map1)
  );

  // Next state of the register bank and strobes
  always_comb begin
    next_st = st;
    next_st.ack = sysreg_valid;
    next_st.undef = sysreg_valid & ~hit_any;
    // Read data only changes on a read, so it holds between accesses
    if (rd) begin
      next_st.rdata = rd_val;
    end
    next_st.drop = 1'b0;
    next_st.deact = 1'b0;
    // Group-0 split write, raised to its floor
    if (wr & hit_bp0) begin
      next_st.bp0 = (wr_bp < BP0_MIN) ? BP0_MIN : wr_bp;
    end
    // Group-1 split write is dropped while shared mode is on
    if (wr & hit_bp1 & ~st.shared) begin
      if (secure_state) begin
        next_st.bp1_s = (wr_bp < BP1_S_MIN) ? BP1_S_MIN : wr_bp;
      end else begin
        next_st.bp1_ns = (wr_bp < BP1_NS_MIN) ? BP1_NS_MIN : wr_bp;
      end
    end
    // Control write keeps only the two writable bits
    if (wr & hit_ctl) begin
      next_st.eoi_split = sysreg_wdata[CTL_EOI_BIT];
      next_st.shared = sysreg_wdata[CTL_SHARED_BIT];
    end
    // End of interrupt: drop always, deactivate only in joint mode
    if (wr & (hit_end0 | hit_end1)) begin
      next_st.drop = 1'b1;
      next_st.drop_grp = hit_end1;
      next_st.deact = ~st.eoi_split;
      next_st.deact_id = sysreg_wdata[ID_W-1:0];
    end
    // Deactivate register acts only in split mode; joint mode ignores it
    if (wr & hit_deact & st.eoi_split) begin
      next_st.deact = 1'b1;
      next_st.deact_id = sysreg_wdata[ID_W-1:0];
    end
    // Effective split points for the preemption logic
    next_st.eff0 = st.bp0;
    next_st.eff1 = st.shared ? st.bp0 : bp1_cur;
  end

  // Registered state; splits come up at their floors
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st.bp0 <= BP0_MIN;
      st.bp1_s <= BP1_S_MIN;
      st.bp1_ns <= BP1_NS_MIN;
      st.eoi_split <= CTL_EOI_RST;
      st.shared <= CTL_SHARED_RST;
      st.ack <= 1'b0;
      st.undef <= 1'b0;
      st.rdata <= 32'h00000000;
      st.drop <= 1'b0;
      st.drop_grp <= 1'b0;
      st.deact <= 1'b0;
      st.deact_id <= 16'h0000;
      st.eff0 <= BP0_MIN;
      st.eff1 <= BP1_NS_MIN;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign sysreg_ack = st.ack;
  assign sysreg_undef = st.undef;
  assign sysreg_rdata = st.rdata;
  assign prio_drop = st.drop;
  assign prio_drop_group = st.drop_grp;
  assign deact = st.deact;
  assign deact_id = st.deact_id;
  assign split_grp0 = st.eff0;
  assign split_grp1 = st.eff1;
  assign ap_grp0 = map0;
  assign ap_grp1 = map1;

  // A low group-0 write lands on the floor
  property p_bp0_floor;
    @(posedge clk_sys) disable iff (!resetn)
      (wr && hit_bp0 && wr_bp < BP0_MIN) |=> (st.bp0 == 3'h2);
  endproperty
  a_bp0_floor: assert property (p_bp0_floor)
    else $error("group-0 split below floor");

  // Group-1 copies never sit below their floors
  property p_bp1_floor;
    @(posedge clk_sys) disable iff (!resetn)
      (st.bp1_ns >= 3'h3) && (st.bp1_s >= 3'h2);
  endproperty
  a_bp1_floor: assert property (p_bp1_floor)
    else $error("group-1 split below floor");

  // Split reads show nothing above bit 2
  property p_resv_zero;
    @(posedge clk_sys) disable iff (!resetn)
      (rd && (hit_bp0 || hit_bp1)) |=> (sysreg_ack && sysreg_rdata[31:3] == 29'h0);
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved split bits not zero");

  // Feature fields of the control read
  property p_ctl_feat;
    @(posedge clk_sys) disable iff (!resetn)
      (rd && hit_ctl) |=> (sysreg_rdata[31:8] == 24'h000084 && sysreg_rdata[7:2] == 6'h00);
  endproperty
  a_ctl_feat: assert property (p_ctl_feat)
    else $error("control feature fields wrong");

  // Joint mode: end write gives drop and deactivate together
  property p_eoi_joint;
    @(posedge clk_sys) disable iff (!resetn)
      (wr && (hit_end0 || hit_end1) && !st.eoi_split) |=> (prio_drop && deact);
  endproperty
  a_eoi_joint: assert property (p_eoi_joint)
    else $error("joint end missed an effect");

  // Split mode: end write drops only, deactivate register deactivates
  property p_eoi_split;
    @(posedge clk_sys) disable iff (!resetn)
      (wr && st.eoi_split && (hit_end0 || hit_end1 || hit_deact)) |=> (deact == $past(hit_deact));
  endproperty
  a_eoi_split: assert property (p_eoi_split)
    else $error("split mode deactivate wrong");

  // Own split per group while shared mode is off
  property p_own_split;
    @(posedge clk_sys) disable iff (!resetn)
      !st.shared ##1 1'b1 |-> (split_grp1 == ($past(secure_state) ? $past(st.bp1_s) : $past(st.bp1_ns)));
  endproperty
  a_own_split: assert property (p_own_split)
    else $error("group-1 split not its own");

  // Shared mode: group-1 write has no effect
  property p_shared_wr;
    @(posedge clk_sys) disable iff (!resetn)
      (wr && hit_bp1 && st.shared) |=> ($stable(st.bp1_s) && $stable(st.bp1_ns));
  endproperty
  a_shared_wr: assert property (p_shared_wr)
    else $error("shared mode took group-1 write");

  // Activation sets the bit for priority divided by eight
  property p_act_set;
    @(posedge clk_sys) disable iff (!resetn)
      (set0) |=> ap_grp0[$past(act_idx)];
  endproperty
  a_act_set: assert property (p_act_set)
    else $error("activation bit not set");

  // Group-0 activity leaves the group-1 map alone
  property p_sep_maps;
    @(posedge clk_sys) disable iff (!resetn)
      (set0 && !drop1 && !(wr && hit_ap1)) |=> $stable(ap_grp1);
  endproperty
  a_sep_maps: assert property (p_sep_maps)
    else $error("group-1 map disturbed");

endmodule

//--- tb/vcir_regs_bench.sv
`timescale 1ns/100ps
module vcir_regs_bench import vcir_pkg::*;;
  // Expected answer of one access
  typedef struct packed {
    logic chk;
    logic [31:0] rd;
    logic undef;
    logic drop;
    logic grp;
    logic deact;
    logic [15:0] id;
  } vcir_exp_s;
  // Flag sets {undef, drop, deact}
  localparam logic [2:0] F_UND = 3'h4;
  localparam logic [2:0] F_DRP = 3'h2;
  localparam logic [2:0] F_DEA = 3'h1;
  // Clock, reset and request side
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic valid = 1'b0;
  logic write = 1'b0;
  logic [16:0] key = 17'h00000;
  logic [31:0] wdata = 32'h00000000;
  logic secure = 1'b0;
  logic act_valid = 1'b0;
  logic act_group = 1'b0;
  logic [7:0] act_prio = 8'h00;
  // Design outputs
  logic ack, undef, drop, drop_grp, deact;
  logic [31:0] rdata, ap0, ap1;
  logic [15:0] id;
  logic [2:0] sp0, sp1;
  // Scoreboard state
  vcir_exp_s exp_q[$];
  vcir_exp_s mon_e;
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] r;

  vcir_regs i_vcir_regs (
    .clk_sys(clk_sys), .resetn(resetn),
    .sysreg_valid(valid), .sysreg_write(write),
    .sysreg_op0(key[16:15]), .sysreg_op1(key[14:12]), .sysreg_crn(key[11:7]),
    .sysreg_crm(key[6:3]), .sysreg_op2(key[2:0]), .sysreg_wdata(wdata),
    .secure_state(secure), .sysreg_ack(ack), .sysreg_rdata(rdata), .sysreg_undef(undef),
    .act_valid(act_valid), .act_group(act_group), .act_prio(act_prio),
    .prio_drop(drop), .prio_drop_group(drop_grp), .deact(deact), .deact_id(id),
    .split_grp0(sp0), .split_grp1(sp1), .ap_grp0(ap0), .ap_grp1(ap1)
  );

  // Free running 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  // One comparison, counted
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // One access per cycle; the answer is noted for the monitor
  task automatic acc(input logic wr, input logic [16:0] k, input logic [31:0] d,
                     input logic [31:0] rd, input logic [2:0] fx);
    vcir_exp_s e;
    @(negedge clk_sys);
    valid = 1'b1;
    act_valid = 1'b0;
    write = wr;
    key = k;
    wdata = d;
    e = '{chk: !wr, rd: rd, undef: fx[2], drop: fx[1], grp: (k == ENC_END_GRP1),
          deact: fx[0], id: d[15:0]};
    exp_q.push_back(e);
  endtask

  task automatic rd(input logic [16:0] k, input logic [31:0] e);
    acc(1'b0, k, 32'h00000000, e, 3'h0);
  endtask

  task automatic wr(input logic [16:0] k, input logic [31:0] d, input logic [2:0] fx = 3'h0);
    acc(1'b1, k, d, 32'h00000000, fx);
  endtask

  // Activation pulse for one cycle
  task automatic act(input logic g, input logic [7:0] p);
    @(negedge clk_sys);
    // A held access strobe would repeat the last access
    valid = 1'b0;
    act_valid = 1'b1;
    act_group = g;
    act_prio = p;
  endtask

  // Release requests, then let effects settle
  task automatic idle(input int n);
    @(negedge clk_sys);
    valid = 1'b0;
    act_valid = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Monitor: every ack takes the oldest note; sampled mid-cycle so outputs are settled
  always @(negedge clk_sys) begin
    if (resetn === 1'b1 && ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp("spare_ack", 32'h0, 32'h1);
      end else begin
        mon_e = exp_q.pop_front();
        if (mon_e.chk) cmp("rdata", mon_e.rd, rdata);
        cmp("undef", 32'(mon_e.undef), 32'(undef));
        cmp("drop", 32'(mon_e.drop), 32'(drop));
        cmp("deact", 32'(mon_e.deact), 32'(deact));
        if (mon_e.drop) cmp("drop_group", 32'(mon_e.grp), 32'(drop_grp));
        if (mon_e.drop || mon_e.deact) cmp("deact_id", 32'(mon_e.id), 32'(id));
      end
    end
  end

  // Watchdog sized well beyond the roughly 150 cycles the tests need
  initial begin
    #(25 * 4000);
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h4237));
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    // Reset view of every register
    rd(ENC_BP_GRP0, 32'h2);
    rd(ENC_BP_GRP1, 32'h3);
    rd(ENC_CONTROL, 32'h00008400);
    rd(ENC_AP_GRP0, 32'h0);
    rd(ENC_AP_GRP1, 32'h0);
    acc(1'b0, 17'h1FFFF, 32'h0, 32'h0, F_UND);
    rd(ENC_END_GRP0, 32'h0);
    idle(3);
    cmp("split_grp0", 32'h2, 32'(sp0));
    cmp("split_grp1", 32'h3, 32'(sp1));
    $display("test reset_values done");
    // Split field sweep with floors; upper bits must vanish
    for (int v = 0; v < 8; v++) begin
      wr(ENC_BP_GRP0, 32'hFFFFFFF8 | v);
      rd(ENC_BP_GRP0, (v < 2) ? 2 : v);
    end
    for (int s = 0; s < 2; s++) begin
      idle(0);
      secure = s[0];
      for (int v = 0; v < 8; v++) begin
        wr(ENC_BP_GRP1, v);
        rd(ENC_BP_GRP1, (v < (s ? 2 : 3)) ? (s ? 2 : 3) : v);
      end
    end
    wr(ENC_BP_GRP1, 32'h0);
    idle(0);
    secure = 1'b0;
    wr(ENC_BP_GRP1, 32'h4);
    idle(3);
    cmp("split_grp1", 32'h4, 32'(sp1));
    secure = 1'b1;
    idle(3);
    cmp("split_grp1", 32'h2, 32'(sp1));
    $display("test split_points done");
    // Shared split: group-1 view is group-0 plus one, writes dropped
    wr(ENC_BP_GRP0, 32'h6);
    wr(ENC_CONTROL, 32'hFFFFFFFD);
    rd(ENC_CONTROL, 32'h00008401);
    rd(ENC_BP_GRP1, 32'h7);
    wr(ENC_BP_GRP0, 32'h7);
    rd(ENC_BP_GRP1, 32'h7);
    wr(ENC_BP_GRP0, 32'h3);
    wr(ENC_BP_GRP1, 32'h5);
    rd(ENC_BP_GRP1, 32'h4);
    idle(3);
    cmp("split_grp1", 32'h3, 32'(sp1));
    cmp("split_grp0", 32'h3, 32'(sp0));
    for (int i = 0; i < 4; i++) begin
      r = 2 + ($urandom % 6);
      wr(ENC_BP_GRP0, r);
      rd(ENC_BP_GRP1, (r == 7) ? 7 : r + 1);
    end
    wr(ENC_CONTROL, 32'h0);
    rd(ENC_BP_GRP1, 32'h2);
    $display("test shared_split done");
    // Activation, end of interrupt in both modes
    act(1'b0, 8'h08);
    act(1'b1, 8'hF8);
    act(1'b1, 8'h0F);
    idle(1);
    cmp("ap_grp0", 32'h00000002, ap0);
    cmp("ap_grp1", 32'h80000002, ap1);
    rd(ENC_AP_GRP0, 32'h00000002);
    rd(ENC_AP_GRP1, 32'h80000002);
    wr(ENC_END_GRP1, 32'h00000025, F_DRP | F_DEA);
    // Joint mode: software leaves the deactivate register alone
    wr(ENC_END_GRP0, 32'h00000011, F_DRP | F_DEA);
    idle(1);
    cmp("ap_grp1", 32'h80000000, ap1);
    cmp("ap_grp0", 32'h00000000, ap0);
    act(1'b0, 8'h10);
    wr(ENC_CONTROL, 32'h2);
    wr(ENC_END_GRP0, 32'h00000033, F_DRP);
    wr(ENC_DEACT, 32'h00000044, F_DEA);
    idle(1);
    cmp("ap_grp0", 32'h0, ap0);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      wr(ENC_AP_GRP0, r);
      wr(ENC_AP_GRP1, ~r);
      rd(ENC_AP_GRP0, r);
      rd(ENC_AP_GRP1, ~r);
    end
    $display("test active_maps done");
    // Reset in mid-run clears both maps
    idle(2);
    resetn = 1'b0;
    idle(2);
    resetn = 1'b1;
    rd(ENC_AP_GRP0, 32'h0);
    rd(ENC_AP_GRP1, 32'h0);
    rd(ENC_CONTROL, 32'h00008400);
    idle(3);
    cmp("pending_notes", 32'h0, exp_q.size());
    $display("test second_reset done");
    give_verdict();
  end
endmodule
